// *** common/asr_regs.svh ***
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// Register offsets
`define ASR_OFS_PRIMARY    8'h01
`define ASR_OFS_SECONDARY  8'h02
`define ASR_OFS_STATUS     8'h03
`define ASR_OFS_EVENT      8'h06
`define ASR_OFS_EVMASK     8'h07

// Reset values
`define ASR_RST_PRIMARY    8'h74
`define ASR_RST_SECONDARY  8'h60
`define ASR_RST_STATUS     8'h00
`define ASR_RST_EVMASK     8'h00

// Writable bits; reserved bits stay zero
`define ASR_WMASK_PRIMARY   8'h7f
`define ASR_WMASK_SECONDARY 8'h7e
`define ASR_WMASK_EVENT     8'h7f

// Primary control fields
`define ASR_P_AUX_EN   6
`define ASR_P_SEC_EN   5
`define ASR_P_CLK_EN   4
`define ASR_P_TRIG_EN  3
`define ASR_P_TRIM_HI  2
`define ASR_P_TRIM_LO  0

// Secondary control fields
`define ASR_S_MASK_AUX  6
`define ASR_S_MASK_SEC  5
`define ASR_S_MASK_FILT 4
`define ASR_S_SEL_HI    3
`define ASR_S_SEL_LO    1

// Status fields
`define ASR_T_AUX   6
`define ASR_T_SEC   5
`define ASR_T_BUS   4
`define ASR_T_FILT  3
`define ASR_T_XTAL  2
`define ASR_T_WARN  1
`define ASR_T_SHUT  0

`endif

// *** common/asr_pkg.sv ***
package asr_pkg;

  typedef logic [7:0] asr_byte_t;

  // Analog output routing
  typedef enum logic [2:0] {
    ASR_AOUT_OFF,
    ASR_AOUT_BUS_V,
    ASR_AOUT_FILT,
    ASR_AOUT_AUX,
    ASR_AOUT_SEC,
    ASR_AOUT_CORE,
    ASR_AOUT_BUS_I,
    ASR_AOUT_TEMP
  } asr_aout_e;

  // Register port request from the host side
  typedef struct packed {
    asr_byte_t addr;
    asr_byte_t wdata;
    logic      wr;
    logic      rd;
  } asr_bus_req_s;

  // Raw monitor and pin levels from the analog core
  typedef struct packed {
    logic aux_regulator_ok;
    logic secondary_supply_ok;
    logic bus_voltage_ok;
    logic filter_supply_ok;
    logic xtal_ok;
    logic thermal_warning;
    logic thermal_shutdown;
    logic tx_activity;
  } asr_mon_s;

  // Control outputs toward the analog core and pins
  typedef struct packed {
    logic      aux_regulator_enable;
    logic      secondary_converter_enable;
    logic      clock_output_enable;
    logic      external_clock_pin_oe;
    logic      activity_trigger_pin_o;
    logic      activity_trigger_pin_oe;
    logic [2:0] aux_regulator_current_trim;
    asr_aout_e analog_output_select;
    logic      analog_output_enable;
    logic      save_warning_n;
  } asr_ctrl_s;

endpackage

// *** rtl/asr_sync.sv ***
`timescale 1ns/100ps
module asr_sync
  import asr_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     sys_rst,
  input  wire asr_mon_s raw,
  output asr_mon_s      synced
);

  typedef struct packed {
    asr_mon_s stage1;
    asr_mon_s stage2;
  } asr_sync_s;

  asr_sync_s st_q;
  asr_sync_s st_d;

  // Stage one feeds only stage two
  always_comb begin
    st_d        = st_q;
    st_d.stage1 = raw;
    st_d.stage2 = st_q.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign synced = st_q.stage2;

endmodule

// *** rtl/asr_irq.sv ***
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_irq
  import asr_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  input  wire asr_byte_t events,
  input  wire asr_byte_t addr,
  input  wire asr_byte_t wdata,
  input  wire logic      wr,
  output asr_byte_t      event_q,
  output asr_byte_t      evmask_q,
  output logic           irq
);

  typedef struct packed {
    asr_byte_t evt;
    asr_byte_t mask;
    logic      irq;
  } asr_irq_s;

  asr_irq_s st_q;
  asr_irq_s st_d;

  // Write one clears; a new event in the same cycle wins
  always_comb begin
    asr_byte_t clr;
    clr = '0;
    st_d = st_q;
    if (wr && addr == `ASR_OFS_EVENT) begin
      clr = wdata;
    end
    if (wr && addr == `ASR_OFS_EVMASK) begin
      st_d.mask = wdata & `ASR_WMASK_EVENT;
    end
    st_d.evt = ((st_q.evt & ~clr) | events) & `ASR_WMASK_EVENT;
    st_d.irq = |(st_d.evt & st_d.mask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '{evt: '0, mask: `ASR_RST_EVMASK, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign event_q  = st_q.evt;
  assign evmask_q = st_q.mask;
  assign irq      = st_q.irq;

endmodule

// *** rtl/asr_top.sv ***
`timescale 1ns/100ps
`include "asr_regs.svh"
// How it works
// [R1] Regulator enable bit switches auxiliary regulator
// [R2] Converter enable bit runs secondary converter
// [R3] Clock pin driven only when enabled
// [R4] Trigger pin shows activity, else floats
// [R5] Three-bit trim steps regulator current limit
// [R6] Primary control bit 7 is reserved
// [R7] Secondary control sits at address 0x02
// [R8] Mask bits 6..4, selector 3..1, reset 0x60
// [R9] Mask zero includes monitor in save warning
// [R10] Selector picks one of seven analog sources, or off
// [R11] Secondary control bits 0, 7 reserved
// [R12] Status at 0x03, read-only, resets zero
// [R13] Status bits six down to zero layout
// [R14] Supply bits high while above threshold
// [R15] Shutdown bit remembers a past shutdown
// [R16] Writes to status, reserved bits ignored
// [R17] Host writes reserved zero, read-modify-write
module asr_top
  import asr_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire asr_bus_req_s bus_req,
  output asr_byte_t         bus_rdata,
  input  wire asr_mon_s     mon_pins,
  output asr_ctrl_s         ctrl,
  output logic              irq
);

  // Block state, except the sync stages and the event flags and mask held in u_irq
  typedef struct packed {
    asr_byte_t primary;
    asr_byte_t secondary;
    asr_byte_t status;
    logic      shut_seen;
    logic      shut_prev;
    asr_byte_t rdata;
    asr_ctrl_s ctrl;
  } asr_state_s;

  asr_state_s st_q;
  asr_state_s st_d;

  asr_mon_s   mon;
  asr_byte_t  events;
  asr_byte_t  event_q;
  asr_byte_t  evmask_q;
  asr_byte_t  status_now;
  logic       wr_primary;
  logic       wr_secondary;

  // Selector code to routing enum
  function automatic asr_aout_e asr_decode_sel(input logic [2:0] sel);
    asr_aout_e r;
    r = ASR_AOUT_OFF;
    unique case (sel)
      3'h0: r = ASR_AOUT_OFF;
      3'h1: r = ASR_AOUT_BUS_V;
      3'h2: r = ASR_AOUT_FILT;
      3'h3: r = ASR_AOUT_AUX;
      3'h4: r = ASR_AOUT_SEC;
      3'h5: r = ASR_AOUT_CORE;
      3'h6: r = ASR_AOUT_BUS_I;
      3'h7: r = ASR_AOUT_TEMP;
    endcase
    return r;
  endfunction

  // Pulls the trim field out of a primary value
  function automatic logic [2:0] asr_trim(input asr_byte_t v);
    return v[`ASR_P_TRIM_HI:`ASR_P_TRIM_LO];
  endfunction

  // Pulls the selector field out of a secondary value
  function automatic logic [2:0] asr_sel(input asr_byte_t v);
    return v[`ASR_S_SEL_HI:`ASR_S_SEL_LO];
  endfunction

  // Monitor pins come from the analog domain
  asr_sync u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .raw     (mon_pins),
    .synced  (mon)
  );

  // Write decode for the control registers
  assign wr_primary   = bus_req.wr && (bus_req.addr == `ASR_OFS_PRIMARY);
  assign wr_secondary = bus_req.wr && (bus_req.addr == `ASR_OFS_SECONDARY); // [R7]

  // Live status value before it is registered
  always_comb begin
    status_now = '0; // [R13]
    status_now[`ASR_T_AUX]  = mon.aux_regulator_ok; // [R14]
    status_now[`ASR_T_SEC]  = mon.secondary_supply_ok; // [R14]
    status_now[`ASR_T_BUS]  = mon.bus_voltage_ok; // [R14]
    status_now[`ASR_T_FILT] = mon.filter_supply_ok; // [R14]
    status_now[`ASR_T_XTAL] = mon.xtal_ok;
    status_now[`ASR_T_WARN] = mon.thermal_warning; // [R14]
    status_now[`ASR_T_SHUT] = st_q.shut_seen; // [R15]
  end

  // Events: any change of a live bit, or a new shutdown
  always_comb begin
    events = (status_now ^ st_q.status);
    events[`ASR_T_SHUT] = mon.thermal_shutdown & ~st_q.shut_prev;
  end

  // Event flags, mask and interrupt line
  asr_irq u_irq (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .events   (events),
    .addr     (bus_req.addr),
    .wdata    (bus_req.wdata),
    .wr       (bus_req.wr),
    .event_q  (event_q),
    .evmask_q (evmask_q),
    .irq      (irq)
  );

  // Next state of the register bank and its outputs
  always_comb begin
    st_d = st_q;

    // Control writes; reserved bits forced to zero
    if (wr_primary) begin
      st_d.primary = bus_req.wdata & `ASR_WMASK_PRIMARY; // [R6] [R16]
    end
    if (wr_secondary) begin
      st_d.secondary = bus_req.wdata & `ASR_WMASK_SECONDARY; // [R11] [R16]
    end
    // No write path to status at all
    st_d.status = status_now; // [R12] [R16]

    // Shutdown memory holds until reset
    st_d.shut_prev = mon.thermal_shutdown;
    if (mon.thermal_shutdown) begin
      st_d.shut_seen = 1'b1; // [R15]
    end

    // Read data only in the cycle after a read
    st_d.rdata = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ASR_OFS_PRIMARY:   st_d.rdata = st_q.primary;
        `ASR_OFS_SECONDARY: st_d.rdata = st_q.secondary;
        `ASR_OFS_STATUS:    st_d.rdata = st_q.status; // [R12]
        `ASR_OFS_EVENT:     st_d.rdata = event_q;
        `ASR_OFS_EVMASK:    st_d.rdata = evmask_q;
        default:            st_d.rdata = '0;
      endcase
    end

    // Regulator and converter switches
    st_d.ctrl.aux_regulator_enable =
      st_d.primary[`ASR_P_AUX_EN]; // [R1]
    st_d.ctrl.secondary_converter_enable =
      st_d.primary[`ASR_P_SEC_EN]; // [R2]

    // Clock pin drive follows its enable
    st_d.ctrl.clock_output_enable =
      st_d.primary[`ASR_P_CLK_EN]; // [R3]
    st_d.ctrl.external_clock_pin_oe =
      st_d.primary[`ASR_P_CLK_EN]; // [R3]

    // Trigger pin floats while disabled
    st_d.ctrl.activity_trigger_pin_oe =
      st_d.primary[`ASR_P_TRIG_EN]; // [R4]
    st_d.ctrl.activity_trigger_pin_o =
      st_d.primary[`ASR_P_TRIG_EN] & mon.tx_activity; // [R4]

    // Trim code passes to the current-limit DAC
    st_d.ctrl.aux_regulator_current_trim =
      asr_trim(st_d.primary); // [R5]

    // Analog output routing
    st_d.ctrl.analog_output_select =
      asr_decode_sel(asr_sel(st_d.secondary)); // [R10]
    st_d.ctrl.analog_output_enable =
      (asr_sel(st_d.secondary) != 3'h0); // [R10]

    // Save warning low when any included supply fails
    // Bus voltage has no mask, so it always counts
    st_d.ctrl.save_warning_n = ~(
        ~mon.bus_voltage_ok
      | (~st_d.secondary[`ASR_S_MASK_AUX]  & ~mon.aux_regulator_ok) // [R9]
      | (~st_d.secondary[`ASR_S_MASK_SEC]  & ~mon.secondary_supply_ok) // [R9]
      | (~st_d.secondary[`ASR_S_MASK_FILT] & ~mon.filter_supply_ok)); // [R9] [R8]
  end

  // Reset to the power-on defaults
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q.primary   <= `ASR_RST_PRIMARY;
      st_q.secondary <= `ASR_RST_SECONDARY; // [R8]
      st_q.status    <= `ASR_RST_STATUS; // [R12]
      st_q.shut_seen <= 1'b0;
      st_q.shut_prev <= 1'b0;
      st_q.rdata     <= '0;
      st_q.ctrl      <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata = st_q.rdata;
  assign ctrl      = st_q.ctrl;

endmodule

// *** test/asr_host.sv ***
`timescale 1ns/100ps
module asr_host
  import asr_pkg::*;
(
  input  wire logic      sys_clk,
  output asr_bus_req_s   bus_req,
  input  wire asr_byte_t bus_rdata
);
  // Idle bus from time zero
  initial bus_req = '0;

  // One-cycle write strobe, released on the edge that samples it
  task automatic wr(input asr_byte_t a, input asr_byte_t d);
    @(posedge sys_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data only stands one cycle, so take it at the next edge
  task automatic rd(input asr_byte_t a, output asr_byte_t d);
    @(posedge sys_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(posedge sys_clk);
    d = bus_rdata;
  endtask

  // Reserved bits read as zero, so they go back out as zero
  task automatic rmw(input asr_byte_t a, input asr_byte_t m, input asr_byte_t d);
    asr_byte_t c;
    rd(a, c);
    wr(a, (c & ~m) | (d & m));
  endtask
endmodule

// *** test/asr_top_asserts.sv ***
`timescale 1ns/100ps
module asr_top_chk
  import asr_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         sys_rst,
  input wire asr_bus_req_s bus_req,
  input wire asr_byte_t    bus_rdata,
  input wire asr_mon_s     mon_pins,
  input wire asr_ctrl_s    ctrl,
  input wire logic         irq
);
  asr_byte_t sec_q;
  asr_byte_t msk_q;
  logic      shut_q;
  logic      wr_sec;
  logic      rd_st;
  logic      warn;

  // Decoded strobes and the expected warning cause
  assign wr_sec = bus_req.wr && bus_req.addr == 8'h02;
  assign rd_st  = bus_req.rd && bus_req.addr == 8'h03;
  assign warn   = !mon_pins.bus_voltage_ok || (!mon_pins.aux_regulator_ok && !sec_q[6]) ||
                  (!mon_pins.secondary_supply_ok && !sec_q[5]) ||
                  (!mon_pins.filter_supply_ok && !sec_q[4]);

  // Shadows of masks and the shutdown record, since the checker cannot see inside
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sec_q <= 8'h60;
      msk_q <= 8'h00;
      shut_q <= 1'b0;
    end else begin
      if (wr_sec) sec_q <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == 8'h07) msk_q <= bus_req.wdata;
      if ($past(rd_st) && bus_rdata[0]) shut_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence prim_wr;
    bus_req.wr && bus_req.addr == 8'h01;
  endsequence
  sequence sec_wr_rd;
    wr_sec ##2 (bus_req.rd && bus_req.addr == 8'h02);
  endsequence

  prim_fields_a: assert property (
    prim_wr |=> {ctrl.aux_regulator_enable, ctrl.secondary_converter_enable,
    ctrl.clock_output_enable, ctrl.activity_trigger_pin_oe,
    ctrl.aux_regulator_current_trim} == $past(bus_req.wdata[6:0]))
    else $error("primary control fields wrong");
  clk_pin_a: assert property (
    ctrl.external_clock_pin_oe == ctrl.clock_output_enable)
    else $error("clock pin enable differs");
  trig_float_a: assert property (
    !ctrl.activity_trigger_pin_oe |-> !ctrl.activity_trigger_pin_o)
    else $error("trigger driven while off");
  sel_decode_a: assert property (
    wr_sec |=> ctrl.analog_output_select == $past(bus_req.wdata[3:1]) &&
    ctrl.analog_output_enable == ($past(bus_req.wdata[3:1]) != 3'h0))
    else $error("analog select wrong");
  sec_back_a: assert property (
    sec_wr_rd |=> bus_rdata == ($past(bus_req.wdata, 3) & 8'h7e))
    else $error("secondary readback wrong");
  top_rsvd_a: assert property (
    bus_req.rd && bus_req.addr inside {8'h01, 8'h02, 8'h03} |=> !bus_rdata[7])
    else $error("bit seven not zero");
  shut_hold_a: assert property (
    rd_st && shut_q |=> bus_rdata[0])
    else $error("shutdown record lost");
  warn_low_a: assert property (
    warn [*5] |-> !ctrl.save_warning_n)
    else $error("save warning missing");
  warn_high_a: assert property (
    !warn [*5] |-> ctrl.save_warning_n)
    else $error("save warning spurious");
  irq_mask_a: assert property (
    (msk_q == 8'h00) [*2] |-> !irq)
    else $error("masked interrupt raised");
endmodule

bind asr_top asr_top_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .mon_pins(mon_pins), .ctrl(ctrl), .irq(irq));

// *** test/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import asr_pkg::*;
;
  logic         sys_clk;
  logic         sys_rst;
  asr_bus_req_s bus_req;
  asr_byte_t    bus_rdata;
  asr_mon_s     mon_pins;
  asr_ctrl_s    ctrl;
  logic         irq;
  int           miscompares;
  int           checked;
  asr_byte_t    v;

  asr_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .mon_pins(mon_pins), .ctrl(ctrl), .irq(irq));
  asr_host u_host (.sys_clk(sys_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input asr_byte_t got, input asr_byte_t exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input asr_byte_t a, input asr_byte_t exp);
    u_host.rd(a, v);
    chk(v, exp);
  endtask
  // Pins are asynchronous; five edges cover sync plus status register
  task automatic pins(input asr_mon_s m);
    @(posedge sys_clk);
    mon_pins <= m;
    repeat (5) @(posedge sys_clk);
  endtask
  function automatic asr_byte_t pctl();
    return {1'b0, ctrl.aux_regulator_enable, ctrl.secondary_converter_enable,
      ctrl.clock_output_enable, ctrl.activity_trigger_pin_oe, ctrl.aux_regulator_current_trim};
  endfunction
  task automatic complete_run();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_reset();
    rchk(8'h01, 8'h74);
    rchk(8'h02, 8'h60);
    rchk(8'h03, 8'h00);
    chk(pctl(), 8'h74);
  endtask
  // Every trim code, with the reserved top bit forced on
  task automatic t_prim();
    asr_byte_t p;
    for (int i = 0; i < 8; i++) begin
      p = 8'(i * 25) & 8'h7f;
      u_host.wr(8'h01, p | 8'h80);
      rchk(8'h01, p);
      chk(pctl(), p);
      chk({7'h0, ctrl.external_clock_pin_oe}, {7'h0, p[4]});
    end
  endtask
  // Every selector code, masks counting, reserved bits forced on
  task automatic t_sec();
    asr_byte_t p;
    for (int i = 0; i < 8; i++) begin
      p = 8'(i * 18);
      u_host.wr(8'h02, p | 8'h81);
      rchk(8'h02, p);
      chk({4'h0, ctrl.analog_output_enable, ctrl.analog_output_select},
        {4'h0, i != 0, 3'(i)});
    end
  endtask
  task automatic t_stat();
    pins(8'hfc);
    rchk(8'h03, 8'h7e);
    u_host.wr(8'h03, 8'h00);
    rchk(8'h03, 8'h7e);
    pins(8'hfe);
    pins(8'hf8);
    rchk(8'h03, 8'h7d);
  endtask
  task automatic t_trig();
    pins(8'hf9);
    u_host.wr(8'h01, 8'h08);
    @(posedge sys_clk);
    chk({6'h0, ctrl.activity_trigger_pin_oe, ctrl.activity_trigger_pin_o}, 8'h03);
    pins(8'hf8);
    chk({6'h0, ctrl.activity_trigger_pin_oe, ctrl.activity_trigger_pin_o}, 8'h02);
    u_host.wr(8'h01, 8'h00);
    @(posedge sys_clk);
    chk({6'h0, ctrl.activity_trigger_pin_oe, ctrl.activity_trigger_pin_o}, 8'h00);
  endtask
  task automatic t_save();
    u_host.wr(8'h02, 8'h00);
    pins(8'he9);
    chk({7'h0, ctrl.save_warning_n}, 8'h00);
    u_host.rmw(8'h02, 8'h10, 8'h10);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, ctrl.save_warning_n}, 8'h01);
  endtask
  task automatic t_irq();
    pins(8'hf9);
    u_host.wr(8'h06, 8'hff);
    u_host.wr(8'h07, 8'h40);
    pins(8'h79);
    chk({7'h0, irq}, 8'h01);
    rchk(8'h06, 8'h40);
    rchk(8'h03, 8'h3d);
    u_host.wr(8'h07, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, irq}, 8'h00);
    u_host.wr(8'h06, 8'h40);
    u_host.wr(8'h07, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, irq}, 8'h00);
    rchk(8'h04, 8'h00);
  endtask
  // Mid-run reset drops the shutdown record and reloads defaults
  task automatic t_rst();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(8'h01, 8'h74);
    rchk(8'h02, 8'h60);
    rchk(8'h03, 8'h3c);
    rchk(8'h07, 8'h00);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    mon_pins = '0;
    miscompares = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_prim();
    t_sec();
    t_stat();
    t_trig();
    t_save();
    t_irq();
    t_rst();
    complete_run();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule
